// ===== core/uart_channel_consts.vh
/*
  Serial channel constants: offsets, fields, reset values, timing.
  Assumes an includer that owns the logic.
*/
// Functional notes
// - Five to nine data bits; parity odd, even, mark, space or none.
// - Nine-bit characters never carry parity; transmitter makes none for them.
// - Stop setting: one or two bits, for five-bit characters 1.5 or two.
// - Hard reset restores defaults; OTP writes blocked under global lock; code samples the lock once, in the first cycle after reset.
// - USB bus reset clears FIFOs and internal state, keeps registers.
// - Power-up line setting 115.2 kbps, 8N1, no flow control.
// - 512-byte transmit FIFO; packet bytes enter only after CRC passes.
// - Transmit shift stage loads next entry only when idle or just finished.
// - Frame: start, data LSB first, optional parity, stop bits.
// - Nine-bit data without transmit wide mode: ninth bit not sent.
// - Transmit wide nine-bit: two FIFO bytes per character, bit 0 is bit 8.
// - Normal receive 5-8 bits: data byte only, zero padded, errors dropped.
// - Normal receive nine bits: low eight bits only, rest dropped.
// - Receive wide 5-8 bits: data byte then status byte P,B,F,O.
// - Receive wide nine bits: ninth bit replaces parity error at bit 0.
// - Nine-bit wide mode ninth bit marks address or data character.
// - Error flags sticky since previous read; each read starts anew.
// - Full 64-byte packet buffered: acknowledge bulk-in with full packet.
// - Under 64 bytes: NAK until idle over three character times, then all.
// - Low-latency bit returns any buffered data on next bulk-in request.
// - Class driver: line coding below 40960 bps turns low latency on.
// - Custom-driver bit set stops line coding forcing class defaults.
`ifndef UART_CHANNEL_CONSTS_VH
`define UART_CHANNEL_CONSTS_VH

// Register byte offsets
`define OFF_LINE_CFG 8'h00
`define OFF_BAUD_DIV 8'h04
`define OFF_ERR_STATUS 8'h08
`define OFF_FIFO_LEVEL 8'h0c

// Line configuration fields
`define LC_BITS_LSB 0
`define LC_PAR_LSB 4
`define LC_STOP2_BIT 7
`define LC_TXWIDE_BIT 8
`define LC_RXWIDE_BIT 9
`define LC_LOWLAT_BIT 10
`define LC_CUSTOM_BIT 11

// Error status and wide status byte fields
`define ERR_PAR_BIT 0
`define ERR_BRK_BIT 1
`define ERR_FRM_BIT 2
`define ERR_OVR_BIT 3

// Parity codes of the line-coding request
`define PAR_NONE 3'h0
`define PAR_ODD 3'h1
`define PAR_EVEN 3'h2
`define PAR_MARK 3'h3
`define PAR_SPACE 3'h4

// Reset values
`define RST_NBITS 4'h8
`define RST_PAR 3'h0

// Timing
`define DEF_DIV 16'h087a
`define LOWLAT_BPS 32'h0000a000
`define MIN_DIV 16'h0002

`endif

// ===== core/usb_uart_channel_datapath.v
/*
  Serial channel datapath: APB registers, FIFOs, shift stages, bulk-in.
  Assumes a USB core committing or aborting bulk-out packets.
*/
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "uart_channel_consts.vh"

module usb_uart_channel_datapath #(
  parameter AW = 9,
  parameter PKT = 64
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Line-coding request from the control endpoint
  input wire lc_valid,
  input wire [31:0] lc_rate,
  input wire [7:0] lc_stop,
  input wire [7:0] lc_parity,
  input wire [7:0] lc_bits,
  // USB bus reset
  input wire usb_bus_reset,
  output reg usb_reenum,
  // OTP write gate
  input wire otp_global_lock,
  input wire otp_wr_req,
  output reg otp_wr_grant,
  // Bulk-out bytes
  input wire out_valid,
  input wire [7:0] out_data,
  input wire out_commit,
  input wire out_abort,
  output reg out_ready,
  // Bulk-in packets
  input wire in_req,
  output reg in_ack,
  output reg in_nak,
  output reg in_valid,
  output reg [7:0] in_data,
  output reg in_last,
  // Serial pins
  input wire uart_rx,
  output reg uart_tx
);

  localparam DEPTH = 1 << AW;
  localparam T_IDLE = 3'h0;
  localparam T_START = 3'h1;
  localparam T_DATA = 3'h2;
  localparam T_PAR = 3'h3;
  localparam T_STOP = 3'h4;

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers
  reg [3:0] nbits_reg;
  reg [2:0] par_reg;
  reg stop2_reg, txw_reg, rxw_reg, lowlat_reg, custom_reg;
  reg [15:0] div_reg;
  reg [3:0] err_reg;
  reg [3:0] err_set;
  reg lock_reg, lock_cap_reg;

  wire nine = (nbits_reg == 4'h9);
  wire par_en = (par_reg != `PAR_NONE) && !nine;
  wire [15:0] half_div = {1'b0, div_reg[15:1]};

  wire acc = psel & penable;
  wire done = acc & pready;
  wire hit = (paddr == `OFF_LINE_CFG) || (paddr == `OFF_BAUD_DIV) ||
             (paddr == `OFF_ERR_STATUS) || (paddr == `OFF_FIFO_LEVEL);

  reg [AW:0] tx_wp, tx_wt, tx_rp, rx_wp, rx_rp;
  wire [AW:0] tx_level = tx_wp - tx_rp;
  wire [AW:0] rx_level = rx_wp - rx_rp;
  wire [AW:0] tx_tmp_level = tx_wt - tx_rp;

  reg [31:0] rd_mux;
  always @* begin
    case (paddr)
      `OFF_LINE_CFG: rd_mux = {20'h0, custom_reg, lowlat_reg, rxw_reg,
                               txw_reg, stop2_reg, par_reg, nbits_reg};
      `OFF_BAUD_DIV: rd_mux = {16'h0, div_reg};
      `OFF_ERR_STATUS: rd_mux = {28'h0, err_reg};
      `OFF_FIFO_LEVEL: rd_mux = {{(15 - AW){1'b0}}, rx_level,
                                 {(15 - AW){1'b0}}, tx_level};
      default: rd_mux = 32'h0;
    endcase
  end

  // Answer in the second access cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc & ~pready)
        prdata <= pwrite ? 32'h0 : rd_mux;
    end
  end

  wire err_clr = done & ~pwrite & (paddr == `OFF_ERR_STATUS);

  // Line coding first, so an APB write in the same cycle wins
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nbits_reg <= `RST_NBITS;
      par_reg <= `RST_PAR;
      stop2_reg <= 1'b0;
      txw_reg <= 1'b0;
      rxw_reg <= 1'b0;
      lowlat_reg <= 1'b0;
      custom_reg <= 1'b0;
      div_reg <= `DEF_DIV;
      err_reg <= 4'h0;
    end else begin
      err_reg <= (err_clr ? 4'h0 : err_reg) | err_set;
      if (lc_valid) begin
        if (lc_bits >= 8'h05 && lc_bits <= 8'h09)
          nbits_reg <= lc_bits[3:0];
        if (lc_bits == 8'h09)
          par_reg <= `PAR_NONE;
        else if (lc_parity <= 8'h04)
          par_reg <= lc_parity[2:0];
        stop2_reg <= (lc_stop == 8'h02);
        if (!custom_reg && lc_rate < `LOWLAT_BPS)
          lowlat_reg <= 1'b1;
      end
      if (done & pwrite) begin
        if (paddr == `OFF_LINE_CFG) begin
          nbits_reg <= pwdata[`LC_BITS_LSB +: 4];
          par_reg <= pwdata[`LC_PAR_LSB +: 3];
          stop2_reg <= pwdata[`LC_STOP2_BIT];
          txw_reg <= pwdata[`LC_TXWIDE_BIT];
          rxw_reg <= pwdata[`LC_RXWIDE_BIT];
          lowlat_reg <= pwdata[`LC_LOWLAT_BIT];
          custom_reg <= pwdata[`LC_CUSTOM_BIT];
        end
        if (paddr == `OFF_BAUD_DIV && pwdata[15:0] >= `MIN_DIV)
          div_reg <= pwdata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // OTP lock and bus reset
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
      lock_cap_reg <= 1'b0;
      otp_wr_grant <= 1'b0;
      usb_reenum <= 1'b0;
    end else begin
      lock_cap_reg <= 1'b1;
      if (!lock_cap_reg)
        lock_reg <= otp_global_lock;
      otp_wr_grant <= otp_wr_req & lock_cap_reg & ~lock_reg;
      usb_reenum <= usb_bus_reset;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit FIFO: staged bytes show on commit only
  reg [7:0] txm [0:DEPTH-1];
  wire tx_push = out_valid & out_ready;
  wire [AW:0] tx_wt_n = tx_wt + {{AW{1'b0}}, tx_push};

  reg [2:0] tst;
  reg [8:0] tsh;
  reg tpar;
  reg [15:0] tcnt;
  reg [3:0] tbit;
  reg [2:0] thalf;
  wire wide9 = txw_reg & nine;
  wire [AW:0] tx_need = {{(AW-1){1'b0}}, wide9, ~wide9};
  wire tx_load = (tst == T_IDLE) && (tx_level >= tx_need);
  wire [7:0] tx_b0 = txm[tx_rp[AW-1:0]];
  wire [AW:0] tx_rp1 = tx_rp + 1'b1;
  wire [7:0] tx_b1 = txm[tx_rp1[AW-1:0]];
  wire [3:0] tx_n = (nine && !txw_reg) ? 4'h8 : nbits_reg;
  wire [2:0] stop_halves = stop2_reg ? 3'h4 :
                           (nbits_reg == 4'h5) ? 3'h3 : 3'h2;
  wire [7:0] tx_mask = 8'hff >> (4'h8 - ((nbits_reg > 4'h8) ? 4'h8 :
                                         nbits_reg));
  wire tx_xor = ^(tx_b0 & tx_mask);
  reg tx_pbit;
  always @* begin
    case (par_reg)
      `PAR_ODD: tx_pbit = ~tx_xor;
      `PAR_EVEN: tx_pbit = tx_xor;
      `PAR_MARK: tx_pbit = 1'b1;
      default: tx_pbit = 1'b0;
    endcase
  end

  always @(posedge clk_sys) begin
    if (tx_push)
      txm[tx_wt[AW-1:0]] <= out_data;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp <= {(AW+1){1'b0}};
      tx_wt <= {(AW+1){1'b0}};
      out_ready <= 1'b0;
    end else if (usb_bus_reset) begin
      tx_wp <= {(AW+1){1'b0}};
      tx_wt <= {(AW+1){1'b0}};
      out_ready <= 1'b0;
    end else begin
      // Margin of two covers the one-cycle lag of the registered ready
      out_ready <= (tx_tmp_level < DEPTH - 2);
      if (out_abort)
        tx_wt <= tx_wp;
      else begin
        tx_wt <= tx_wt_n;
        if (out_commit)
          tx_wp <= tx_wt_n;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit shift stage
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tst <= T_IDLE;
      tsh <= 9'h0;
      tpar <= 1'b0;
      tcnt <= 16'h0;
      tbit <= 4'h0;
      thalf <= 3'h0;
      tx_rp <= {(AW+1){1'b0}};
      uart_tx <= 1'b1;
    end else if (usb_bus_reset) begin
      tst <= T_IDLE;
      tx_rp <= {(AW+1){1'b0}};
      uart_tx <= 1'b1;
    end else begin
      if (tcnt != 16'h0)
        tcnt <= tcnt - 1'b1;
      case (tst)
        T_IDLE: begin
          if (tx_load) begin
            tsh <= {wide9 & tx_b1[0], tx_b0};
            tpar <= tx_pbit;
            tx_rp <= tx_rp + tx_need;
            uart_tx <= 1'b0;
            tcnt <= div_reg - 1'b1;
            tst <= T_START;
          end
        end
        T_START: begin
          if (tcnt == 16'h0) begin
            uart_tx <= tsh[0];
            tsh <= {1'b0, tsh[8:1]};
            tbit <= 4'h0;
            tcnt <= div_reg - 1'b1;
            tst <= T_DATA;
          end
        end
        T_DATA: begin
          if (tcnt == 16'h0) begin
            tcnt <= div_reg - 1'b1;
            tbit <= tbit + 1'b1;
            if (tbit == tx_n - 1'b1) begin
              if (par_en) begin
                uart_tx <= tpar;
                tst <= T_PAR;
              end else begin
                uart_tx <= 1'b1;
                thalf <= 3'h0;
                tcnt <= half_div - 1'b1;
                tst <= T_STOP;
              end
            end else begin
              uart_tx <= tsh[0];
              tsh <= {1'b0, tsh[8:1]};
            end
          end
        end
        T_PAR: begin
          if (tcnt == 16'h0) begin
            uart_tx <= 1'b1;
            thalf <= 3'h0;
            tcnt <= half_div - 1'b1;
            tst <= T_STOP;
          end
        end
        T_STOP: begin
          if (tcnt == 16'h0) begin
            tcnt <= half_div - 1'b1;
            thalf <= thalf + 1'b1;
            if (thalf == stop_halves - 1'b1)
              tst <= T_IDLE;
          end
        end
        default: tst <= T_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive shift stage
  reg rx_s1, rx_s2, rx_s3, rx_filt, rx_prev;
  reg [2:0] rst_q;
  reg [8:0] rsh;
  reg rpe, rzero, ovr_pend;
  reg [15:0] rcnt;
  reg [3:0] rbit;
  reg [7:0] rxm [0:DEPTH-1];
  wire [8:0] rdat = rsh >> (4'h9 - nbits_reg);
  wire [AW:0] rx_need = {{(AW-1){1'b0}}, rxw_reg, ~rxw_reg};
  wire rx_room = (DEPTH - rx_level) >= rx_need;
  wire rx_tick = (rcnt == 16'h0);
  wire rx_done = (rst_q == T_STOP) && rx_tick;
  wire rx_fe = ~rx_filt;
  wire rx_brk = rzero & ~rx_filt;
  wire rx_xor = ^rdat[7:0];
  reg rx_pexp;
  always @* begin
    case (par_reg)
      `PAR_ODD: rx_pexp = ~rx_xor;
      `PAR_EVEN: rx_pexp = rx_xor;
      `PAR_MARK: rx_pexp = 1'b1;
      default: rx_pexp = 1'b0;
    endcase
  end
  wire [7:0] rx_stat = {4'h0, ovr_pend | ~rx_room, rx_fe, rx_brk,
                        nine ? rdat[8] : rpe};
  wire [AW:0] rx_wp1 = rx_wp + 1'b1;

  always @(posedge clk_sys) begin
    if (rx_done && rx_room) begin
      rxm[rx_wp[AW-1:0]] <= rdat[7:0];
      if (rxw_reg)
        rxm[rx_wp1[AW-1:0]] <= rx_stat;
    end
  end

  always @* begin
    err_set = 4'h0;
    if (rx_done) begin
      err_set[`ERR_PAR_BIT] = rpe;
      err_set[`ERR_BRK_BIT] = rx_brk;
      err_set[`ERR_FRM_BIT] = rx_fe;
      err_set[`ERR_OVR_BIT] = ~rx_room;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_filt <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1 <= uart_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3)
        rx_filt <= rx_s3;
      rx_prev <= rx_filt;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= T_IDLE;
      rsh <= 9'h0;
      rpe <= 1'b0;
      rzero <= 1'b0;
      ovr_pend <= 1'b0;
      rcnt <= 16'h0;
      rbit <= 4'h0;
      rx_wp <= {(AW+1){1'b0}};
    end else if (usb_bus_reset) begin
      rst_q <= T_IDLE;
      ovr_pend <= 1'b0;
      rx_wp <= {(AW+1){1'b0}};
    end else begin
      if (rcnt != 16'h0)
        rcnt <= rcnt - 1'b1;
      case (rst_q)
        T_IDLE: begin
          if (rx_prev & ~rx_filt) begin
            rcnt <= half_div - 1'b1;
            rst_q <= T_START;
          end
        end
        T_START: begin
          if (rx_tick) begin
            rcnt <= div_reg - 1'b1;
            rbit <= 4'h0;
            rzero <= 1'b1;
            rpe <= 1'b0;
            rst_q <= rx_filt ? T_IDLE : T_DATA;
          end
        end
        T_DATA: begin
          if (rx_tick) begin
            rcnt <= div_reg - 1'b1;
            rsh <= {rx_filt, rsh[8:1]};
            rzero <= rzero & ~rx_filt;
            rbit <= rbit + 1'b1;
            if (rbit == nbits_reg - 1'b1)
              rst_q <= par_en ? T_PAR : T_STOP;
          end
        end
        T_PAR: begin
          if (rx_tick) begin
            rcnt <= div_reg - 1'b1;
            rpe <= (rx_filt != rx_pexp);
            rzero <= rzero & ~rx_filt;
            rst_q <= T_STOP;
          end
        end
        T_STOP: begin
          if (rx_tick) begin
            rst_q <= T_IDLE;
            if (rx_room) begin
              rx_wp <= rx_wp + rx_need;
              ovr_pend <= 1'b0;
            end else
              ovr_pend <= 1'b1;
          end
        end
        default: rst_q <= T_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bulk-in release and idle timer
  reg [6:0] scnt;
  reg [23:0] idle_cnt;
  wire [3:0] char_bits = 4'h2 + nbits_reg + {3'h0, par_en} +
                         {3'h0, stop2_reg};
  wire [5:0] cb3 = {2'h0, char_bits} + {1'h0, char_bits, 1'b0};
  wire [23:0] idle_lim = {18'h0, cb3} * {8'h0, div_reg};
  wire idle_exp = (idle_cnt > idle_lim);
  wire [AW:0] pkt_w = PKT[AW:0];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= 24'h0;
    end else if (usb_bus_reset || (rx_done && rx_room)) begin
      idle_cnt <= 24'h0;
    end else if (idle_cnt != 24'hffffff) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scnt <= 7'h0;
      rx_rp <= {(AW+1){1'b0}};
      in_ack <= 1'b0;
      in_nak <= 1'b0;
      in_valid <= 1'b0;
      in_data <= 8'h0;
      in_last <= 1'b0;
    end else if (usb_bus_reset) begin
      scnt <= 7'h0;
      rx_rp <= {(AW+1){1'b0}};
      in_ack <= 1'b0;
      in_nak <= 1'b0;
      in_valid <= 1'b0;
      in_last <= 1'b0;
    end else begin
      in_ack <= 1'b0;
      in_nak <= 1'b0;
      in_valid <= 1'b0;
      in_last <= 1'b0;
      if (scnt != 7'h0) begin
        in_valid <= 1'b1;
        in_data <= rxm[rx_rp[AW-1:0]];
        in_last <= (scnt == 7'h1);
        rx_rp <= rx_rp + 1'b1;
        scnt <= scnt - 1'b1;
      end else if (in_req) begin
        if (rx_level >= pkt_w) begin
          in_ack <= 1'b1;
          scnt <= pkt_w[6:0];
        end else if (rx_level != 0 && (lowlat_reg || idle_exp)) begin
          in_ack <= 1'b1;
          scnt <= rx_level[6:0];
        end else
          in_nak <= 1'b1;
      end
    end
  end

endmodule // usb_uart_channel_datapath
`default_nettype wire

// ===== tb/channel_asserts.sv
/*
  Port checks: APB timing, bus reset, OTP gate, bulk-in stream.
  Assumes a bind to the datapath top module.
*/
`timescale 1ns/1ns
`default_nettype none
module channel_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Bus reset and OTP gate
  input wire logic usb_bus_reset,
  input wire logic usb_reenum,
  input wire logic otp_global_lock,
  input wire logic otp_wr_req,
  input wire logic otp_wr_grant,
  // Bulk paths and line
  input wire logic out_ready,
  input wire logic in_ack,
  input wire logic in_nak,
  input wire logic in_valid,
  input wire logic in_last,
  input wire logic uart_tx
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered in second cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  reenum_follow_a: assert property (usb_reenum == $past(usb_bus_reset))
    else $error("re-enumeration does not follow bus reset");
  busrst_quiet_a: assert property (usb_bus_reset [*2] |->
    uart_tx && !out_ready)
    else $error("line or bulk-out active during bus reset");
  otp_grant_a: assert property (otp_wr_req && !otp_global_lock |=>
    otp_wr_grant)
    else $error("OTP write not granted while unlocked");
  otp_lock_a: assert property (otp_global_lock |-> !otp_wr_grant)
    else $error("OTP write granted while locked");
  ack_stream_a: assert property (in_ack |-> !in_nak ##1 in_valid)
    else $error("acknowledge not followed by data");
  stream_run_a: assert property (in_valid && !in_last |=> in_valid)
    else $error("bulk-in stream gap");
  last_end_a: assert property (in_last |-> in_valid ##1 !in_valid)
    else $error("stream does not end after last byte");
  cover property (pslverr);
  cover property (in_ack ##1 in_valid [*3]);
  cover property (in_nak);
  cover property (usb_bus_reset ##1 usb_reenum);
endmodule // channel_chk
bind usb_uart_channel_datapath channel_chk chk (.clk_sys, .rst_n, .psel,
  .penable, .pready, .pslverr, .usb_bus_reset, .usb_reenum,
  .otp_global_lock, .otp_wr_req, .otp_wr_grant, .out_ready, .in_ack,
  .in_nak, .in_valid, .in_last, .uart_tx);
`default_nettype wire

// ===== tb/remote_uart.sv
/*
  Remote UART model: drives RX frames, samples TX frames.
  Assumes div matches the channel's bit divisor.
*/
`timescale 1ns/1ns
`default_nettype none
module remote_uart (
  // Clock
  input wire logic clk_sys,
  // Serial lines
  output logic line_out,
  input wire logic line_in
);
  int div = 16;
  initial line_out = 1'b1;
  // One frame; parity bit unless pb < 0
  task automatic send(input logic [8:0] d, input int nb, pb,
    input logic stp);
    logic [11:0] f;
    int n;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i + 1] = d[i];
    n = nb + 1;
    if (pb >= 0) f[n] = pb[0];
    n += (pb >= 0);
    f[n] = stp;
    for (int i = 0; i <= n; i++) begin
      line_out <= f[i];
      repeat (div) @(posedge clk_sys);
    end
    line_out <= 1'b1;
    repeat (div) @(posedge clk_sys);
  endtask
  // n mid-bit samples from the start edge; rest read 1
  task automatic grab(input int n, output logic [11:0] f);
    f = '1;
    while (line_in !== 1'b0) @(posedge clk_sys);
    repeat (div / 2) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (div) @(posedge clk_sys);
      f[i] = line_in;
    end
  endtask
endmodule // remote_uart
`default_nettype wire

// ===== tb/tb.sv
/*
  Self-checking bench for the channel datapath.
  Assumes the remote UART model and bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uart_channel_consts.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  error_cnt++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, lc_stop, lc_parity, lc_bits, out_data, in_data;
  logic [31:0] pwdata, prdata, lc_rate, rd, rnd;
  logic lc_valid, usb_bus_reset, usb_reenum, otp_global_lock, otp_wr_req;
  logic otp_wr_grant, out_valid, out_commit, out_abort, out_ready, ack;
  logic in_req, in_ack, in_nak, in_valid, in_last, uart_rx, uart_tx;
  logic [11:0] fr;
  logic [8:0] d;
  logic [7:0] got[$];
  int error_cnt = 0, cmp_count = 0, cyc = 0, nb, pa, s2, tw, nbs;
  usb_uart_channel_datapath uut (.clk_sys, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .lc_valid,
    .lc_rate, .lc_stop, .lc_parity, .lc_bits, .usb_bus_reset, .usb_reenum,
    .otp_global_lock, .otp_wr_req, .otp_wr_grant, .out_valid, .out_data,
    .out_commit, .out_abort, .out_ready, .in_req, .in_ack, .in_nak,
    .in_valid, .in_data, .in_last, .uart_rx, .uart_tx);
  remote_uart far (.clk_sys, .line_out(uart_rx), .line_in(uart_tx));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] cfg(input int nb, pa, s2, tw, rw, ll);
    return nb | pa << `LC_PAR_LSB | s2 << `LC_STOP2_BIT |
      tw << `LC_TXWIDE_BIT | rw << `LC_RXWIDE_BIT | ll << `LC_LOWLAT_BIT;
  endfunction
  function automatic logic [11:0] exp_tx(input logic [8:0] d,
    input int nbs, pa);
    logic [11:0] f;
    logic p;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nbs; i++) f[i + 1] = d[i];
    p = ^(d & 9'((1 << nbs) - 1));
    if (pa != 0) f[nbs + 1] = (pa == 1) ? ~p : (pa == 2) ? p : (pa == 3);
    return f;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] v);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk_sys);
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  task automatic lc(input logic [31:0] r, input logic [7:0] s, p, b);
    {lc_valid, lc_rate, lc_stop, lc_parity, lc_bits} <= {1'b1, r, s, p, b};
    @(posedge clk_sys);
    lc_valid <= 1'b0;
    step(2);
  endtask
  task automatic put(input logic [7:0] b);
    {out_valid, out_data} <= {1'b1, b};
    do @(posedge clk_sys); while (out_ready !== 1'b1);
  endtask
  task automatic pkt_end(input logic ab);
    {out_valid, out_commit, out_abort} <= {1'b0, !ab, ab};
    @(posedge clk_sys);
    {out_commit, out_abort} <= 2'b00;
  endtask
  task automatic bulk_in();
    got.delete();
    in_req <= 1'b1;
    @(posedge clk_sys);
    in_req <= 1'b0;
    do @(posedge clk_sys); while (in_ack !== 1'b1 && in_nak !== 1'b1);
    ack = (in_ack === 1'b1);
    if (ack) do begin
      @(posedge clk_sys);
      if (in_valid === 1'b1) got.push_back(in_data);
    end while (in_last !== 1'b1);
  endtask
  task automatic rxc(input int nb, pa, rw, pb, e1, input logic [8:0] v,
    input logic stp);
    apb(1'b1, `OFF_LINE_CFG, cfg(nb, pa, 0, 0, rw, 1));
    far.send(v, nb, pb, stp);
    bulk_in();
    `CHK("rx count", rw + 1, got.size())
    `CHK("rx data", 8'(v & 9'((1 << nb) - 1)), got[0])
    if (rw != 0) `CHK("rx status", e1[7:0], got[1])
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, lc_valid, usb_bus_reset} = '0;
    {otp_wr_req, out_valid, out_commit, out_abort, in_req} = '0;
    {paddr, pwdata, lc_rate, lc_stop, lc_parity, lc_bits, out_data} = '0;
    otp_global_lock = 1'b1;
    rnd = 32'h0297c8ff;
    step(8);
    rst_n <= 1'b1;
    step(2);
    rchk("cfg reset", `OFF_LINE_CFG, 32'h8);
    rchk("div reset", `OFF_BAUD_DIV, `DEF_DIV);
    rchk("unmapped", 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, `OFF_BAUD_DIV, 32'h10);
    apb(1'b1, `OFF_BAUD_DIV, 32'h1);
    rchk("div low refused", `OFF_BAUD_DIV, 32'h10);
    otp_wr_req <= 1'b1;
    step(3);
    `CHK("otp locked", 1'b0, otp_wr_grant)
    otp_wr_req <= 1'b0;
    for (int p = 0; p < 5; p++) begin
      rnd = lfsr(rnd);
      nb = 5 + rnd[1:0];
      lc(115200, 8'd0, 8'(p), 8'(nb));
      rchk("lc cfg", `OFF_LINE_CFG, cfg(nb, p, 0, 0, 0, 0));
    end
    lc(115200, 8'd2, 8'd2, 8'd9);
    rchk("lc nine", `OFF_LINE_CFG, cfg(9, 0, 1, 0, 0, 0));
    lc(115200, 8'd0, 8'd0, 8'd4);
    rchk("lc size refused", `OFF_LINE_CFG, cfg(9, 0, 0, 0, 0, 0));
    lc(9600, 8'd0, 8'd0, 8'd8);
    rchk("lc slow", `OFF_LINE_CFG, cfg(8, 0, 0, 0, 0, 1));
    apb(1'b1, `OFF_LINE_CFG, 32'h808);
    lc(9600, 8'd0, 8'd0, 8'd7);
    rchk("lc custom", `OFF_LINE_CFG, 32'h807);
    put(8'h5a);
    put(8'h3c);
    pkt_end(1'b1);
    rchk("tx abort", `OFF_FIFO_LEVEL, 32'h0);
    // Every size and parity, then nine-bit plain and nine-bit wide
    for (int k = 0; k < 22; k++) begin
      rnd = lfsr(rnd);
      nb = (k < 20) ? 5 + k / 5 : 9;
      pa = (k < 20) ? k % 5 : 0;
      tw = (k == 21);
      s2 = (nb > 5) && rnd[12];
      d = rnd[8:0];
      apb(1'b1, `OFF_LINE_CFG, cfg(nb, pa, s2, tw, 0, 0));
      put(d[7:0]);
      if (tw != 0) put({7'h0, d[8]});
      pkt_end(1'b0);
      nbs = (nb == 9 && tw == 0) ? 8 : nb;
      far.grab(2 + nbs + (pa != 0) + s2, fr);
      `CHK("tx frame", exp_tx(d, nbs, pa), fr)
      step(16);
    end
    rnd = lfsr(rnd);
    rxc(8, 0, 0, -1, 0, rnd[8:0], 1'b1);
    rxc(7, 2, 0, ^rnd[6:0], 0, rnd[8:0], 1'b1);
    rxc(9, 0, 0, -1, 0, rnd[8:0], 1'b1);
    rxc(8, 2, 1, ~^rnd[7:0], 1, rnd[8:0], 1'b1);
    rxc(6, 0, 1, -1, 4, rnd[8:0] | 9'h1, 1'b0);
    rxc(9, 0, 1, -1, 1, rnd[8:0] | 9'h100, 1'b1);
    rxc(9, 0, 1, -1, 0, rnd[8:0] & 9'hff, 1'b1);
    rchk("err sticky", `OFF_ERR_STATUS, 32'h5);
    rchk("err cleared", `OFF_ERR_STATUS, 32'h0);
    apb(1'b1, `OFF_LINE_CFG, cfg(8, 0, 0, 0, 0, 0));
    far.send(rnd[8:0], 8, -1, 1'b1);
    far.send(rnd[16:8], 8, -1, 1'b1);
    bulk_in();
    `CHK("early nak", 1'b0, ack)
    step(600);
    bulk_in();
    `CHK("idle release", 2, got.size())
    for (int k = 0; k < 64; k++) begin
      rnd = lfsr(rnd);
      far.send(rnd[8:0], 8, -1, 1'b1);
    end
    bulk_in();
    `CHK("full packet", 64, got.size())
    far.send(rnd[8:0], 8, -1, 1'b1);
    usb_bus_reset <= 1'b1;
    step(3);
    usb_bus_reset <= 1'b0;
    step(2);
    rchk("bus reset level", `OFF_FIFO_LEVEL, 32'h0);
    rchk("bus reset cfg", `OFF_LINE_CFG, cfg(8, 0, 0, 0, 0, 0));
    rchk("bus reset div", `OFF_BAUD_DIV, 32'h10);
    {rst_n, otp_global_lock} <= 2'b00;
    step(8);
    rst_n <= 1'b1;
    step(2);
    rchk("cfg rereset", `OFF_LINE_CFG, 32'h8);
    rchk("div rereset", `OFF_BAUD_DIV, `DEF_DIV);
    otp_wr_req <= 1'b1;
    step(3);
    `CHK("otp open", 1'b1, otp_wr_grant)
    wrap_up();
  end
endmodule // tb
`default_nettype wire
